// >>> verilog/msr_router.sv
// Routing core of one gateway serial port in multidrop master or dual slave mode.
// Assumes a framer that delivers decoded requests and a serializer that signals txDone.
`timescale 1ns/100ps
module msr_router #(
   parameter int TICK_CYC = msr_pkg::TICK_CYC
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire msr_pkg::msr_axi_req_t axiReq,
   output msr_pkg::msr_axi_rsp_t axiRsp,
   input wire logic msgValid,
   output logic msgReady,
   input wire msr_pkg::msr_msg_t msg,
   output logic rts,
   input wire logic cts,
   output logic txValid,
   input wire logic txDone,
   output msr_pkg::msr_tx_t tx,
   input wire logic replyIn,
   output logic ansValid,
   output msr_pkg::msr_ans_t ans
);
   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [6:0][31:0] cfg;
      logic awHeld;
      logic [11:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      msr_pkg::msr_state_t state;
      msr_pkg::msr_tx_t tx;
      logic viaRts;
      logic fwdMb;
      logic ansValid;
      msr_pkg::msr_ans_t ans;
      logic [23:0] tickCnt;
      logic [15:0] timer;
      logic [15:0] tokTimer;
      logic [3:0] tries;
      logic [7:0] msgCnt;
      logic [7:0] rejCnt;
   } msr_st_t;

   msr_st_t s;
   msr_st_t next_s;
   logic [8:0] tab [256];
   logic tabWe;
   logic [7:0] tabIx;
   logic [8:0] tabWd;
   logic tick;
   logic timeUp;
   logic awready;
   logic wready;
   logic arready;
   msr_pkg::msr_mode_t mode;
   logic [7:0] ownDrop;
   logic [15:0] ctsWait;
   logic [15:0] pauseTime;
   logic [7:0] msgCount;
   logic [3:0] attempts;
   logic [15:0] replyTout;
   logic [15:0] tokInterval;

   function automatic msr_pkg::msr_rkind_t regKind(input logic [11:0] a);
      if (a[11:10] == msr_pkg::ADDR_TAB[11:10]) begin
         regKind = msr_pkg::RK_TAB;
      end else if (a[11:5] != 7'h00) begin
         regKind = msr_pkg::RK_NONE;
      end else if (a[4:2] == msr_pkg::ADDR_STAT[4:2]) begin
         regKind = msr_pkg::RK_STAT;
      end else begin
         regKind = msr_pkg::RK_CFG;
      end
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         merge[8*i +: 8] = be[i] ? d[8*i +: 8] : old[8*i +: 8];
      end
   endfunction

   // Modbus frames carry a CRC, routed frames a block check; anything else is noise
   function automatic logic isMbFrame(input msr_pkg::msr_msg_t m);
      isMbFrame = m.crcOk && !m.bccOk;
   endfunction

   assign mode = msr_pkg::msr_mode_t'(s.cfg[msr_pkg::ADDR_CTRL[4:2]][msr_pkg::CTRL_MODE_LSB +: 2]);
   assign ownDrop = s.cfg[msr_pkg::ADDR_DROP[4:2]][7:0];
   assign ctsWait = s.cfg[msr_pkg::ADDR_CTS[4:2]][15:0];
   assign pauseTime = s.cfg[msr_pkg::ADDR_PACE[4:2]][15:0];
   assign msgCount = s.cfg[msr_pkg::ADDR_PACE[4:2]][msr_pkg::PACE_CNT_LSB +: 8];
   assign attempts = s.cfg[msr_pkg::ADDR_RETRY[4:2]][3:0];
   assign replyTout = s.cfg[msr_pkg::ADDR_TOUT[4:2]][15:0];
   assign tokInterval = s.cfg[msr_pkg::ADDR_TOKEN[4:2]][15:0];
   assign timeUp = (s.timer >= replyTout);

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      next_s = s;
      tabWe = 1'b0;
      tabIx = s.awAddr[9:2];
      tabWd = '0;
      next_s.ansValid = 1'b0;
      tick = (s.tickCnt == 24'(TICK_CYC - 1));
      next_s.tickCnt = tick ? 24'h000000 : s.tickCnt + 24'h000001;
      if (tick && s.state != msr_pkg::ST_IDLE && s.timer != 16'hFFFF) begin
         next_s.timer = s.timer + 16'h0001;
      end
      if (mode == msr_pkg::MODE_MDM && s.cfg[msr_pkg::ADDR_CTRL[4:2]][msr_pkg::CTRL_AUTO] && tick &&
         s.tokTimer != 16'hFFFF) begin
         next_s.tokTimer = s.tokTimer + 16'h0001;
      end
      unique case (s.state)
         msr_pkg::ST_IDLE: begin
            next_s.timer = 16'h0000;
            next_s.tries = 4'h1;
            next_s.viaRts = 1'b0;
            next_s.fwdMb = 1'b0;
            if (msgValid) begin
               if (mode == msr_pkg::MODE_MDM) begin
                  if (msg.fromPort) begin
                     if (isMbFrame(msg)) begin
                        next_s.rejCnt = s.rejCnt + 8'h01; // see (R5)
                     end
                  end else if (msg.drop1 <= msr_pkg::DROP_PKT_MAX) begin
                     next_s.tx = '{dest: msr_pkg::DST_PKT, addr: msg.drop1}; // see (R1)
                     next_s.viaRts = 1'b1;
                     next_s.state = msr_pkg::ST_RTS;
                  end else if (msg.drop1 <= msr_pkg::DROP_MB_HI) begin
                     next_s.tx = '{dest: msr_pkg::DST_MB, addr: msg.drop1 - msr_pkg::DROP_MB_LO}; // see (R2)
                     next_s.viaRts = 1'b1;
                     next_s.state = msr_pkg::ST_RTS;
                  end else begin
                     // Beyond the Modbus window there is no repeater path to fall back on
                     next_s.ansValid = 1'b1; // see (R4)
                     next_s.ans = '{err: 1'b1, isLocal: 1'b0};
                  end
               end else if (mode == msr_pkg::MODE_DUAL && msg.fromPort) begin
                  if (isMbFrame(msg)) begin // see (R21)
                     if (msg.mbAddr == msr_pkg::MB_LOCAL) begin
                        next_s.ansValid = 1'b1; // see (R17)
                        next_s.ans = '{err: 1'b0, isLocal: 1'b1};
                     end else if (tab[msg.mbAddr][msr_pkg::TAB_VALID]) begin
                        next_s.tx = '{dest: msr_pkg::DST_FWD, addr: tab[msg.mbAddr][7:0]}; // see (R17)
                        next_s.fwdMb = 1'b1;
                        next_s.state = msr_pkg::ST_SEND;
                     end
                  end else if (msg.bccOk) begin
                     next_s.ansValid = 1'b1; // see (R14)
                     next_s.ans = '{err: 1'b1, isLocal: 1'b0};
                     if (msg.routeLen == 4'h0) begin
                        next_s.ans = '{err: 1'b0, isLocal: 1'b1}; // see (R16)
                     end else if (msg.drop0 == ownDrop || msg.drop0 == msr_pkg::DROP_WILD) begin
                        next_s.ansValid = 1'b0;
                        next_s.tx = '{dest: msr_pkg::DST_FWD, addr: msg.drop1};
                        next_s.state = msr_pkg::ST_SEND;
                     end
                  end
               end
            end else if (mode == msr_pkg::MODE_MDM && (s.cfg[msr_pkg::ADDR_CTRL[4:2]][msr_pkg::CTRL_POLL] ||
               (s.cfg[msr_pkg::ADDR_CTRL[4:2]][msr_pkg::CTRL_AUTO] && tokInterval != 16'h0000 &&
               s.tokTimer >= tokInterval))) begin
               next_s.cfg[msr_pkg::ADDR_CTRL[4:2]][msr_pkg::CTRL_POLL] = 1'b0; // see (R9)
               next_s.tokTimer = 16'h0000;
               next_s.tx = '{dest: msr_pkg::DST_POLL, addr: ownDrop};
               next_s.viaRts = 1'b1;
               next_s.state = msr_pkg::ST_RTS;
            end
         end
         msr_pkg::ST_RTS: begin
            // Handshake wait and CTS must both be met; a zero wait leaves CTS alone
            if (s.timer >= ctsWait && cts) begin // see (R20) (R6)
               next_s.state = msr_pkg::ST_SEND;
            end
         end
         msr_pkg::ST_SEND: begin
            if (txDone) begin
               next_s.timer = 16'h0000;
               next_s.state = msr_pkg::ST_WAIT;
            end
         end
         msr_pkg::ST_WAIT: begin
            if (replyIn || timeUp) begin
               next_s.state = msr_pkg::ST_IDLE;
               if (!replyIn && s.tx.dest == msr_pkg::DST_PKT && s.tries < attempts) begin
                  next_s.tries = s.tries + 4'h1; // see (R7)
                  next_s.timer = 16'h0000;
                  next_s.state = msr_pkg::ST_RTS;
               end else begin
                  if (s.tx.dest != msr_pkg::DST_POLL && !(s.fwdMb && !replyIn)) begin
                     next_s.ansValid = 1'b1; // see (R7) (R14)
                     next_s.ans = '{err: !replyIn, isLocal: 1'b0};
                  end
                  if (s.viaRts) begin
                     next_s.msgCnt = s.msgCnt + 8'h01; // see (R6)
                     if (msgCount == 8'h00 || s.msgCnt + 8'h01 >= msgCount) begin
                        next_s.msgCnt = 8'h00;
                        next_s.timer = 16'h0000;
                        next_s.state = msr_pkg::ST_PAUSE;
                     end
                  end
               end
            end
         end
         msr_pkg::ST_PAUSE: begin
            if (s.timer >= pauseTime) begin // see (R6)
               next_s.state = msr_pkg::ST_IDLE;
            end
         end
         default: begin
            next_s.state = msr_pkg::ST_IDLE;
         end
      endcase
      // ************************************************************
      // AXI4-Lite slave; placed after the engine so a poll write wins over its clear
      // ************************************************************
      awready = !s.awHeld && !s.bvalid;
      wready = !s.wHeld && !s.bvalid;
      arready = !s.rvalid;
      if (axiReq.awvalid && awready) begin
         next_s.awHeld = 1'b1;
         next_s.awAddr = axiReq.awaddr;
      end
      if (axiReq.wvalid && wready) begin
         next_s.wHeld = 1'b1;
         next_s.wData = axiReq.wdata;
         next_s.wStrb = axiReq.wstrb;
      end
      if (s.awHeld && s.wHeld) begin
         next_s.awHeld = 1'b0;
         next_s.wHeld = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = msr_pkg::RESP_OKAY;
         unique case (regKind(s.awAddr))
            msr_pkg::RK_CFG: begin
               next_s.cfg[s.awAddr[4:2]] = merge(next_s.cfg[s.awAddr[4:2]], s.wData, s.wStrb) &
                  msr_pkg::CFG_MASK[s.awAddr[4:2]];
            end
            msr_pkg::RK_TAB: begin
               tabWe = 1'b1;
               tabWd = 9'(merge({23'h000000, tab[tabIx]}, s.wData, s.wStrb));
            end
            msr_pkg::RK_STAT, msr_pkg::RK_NONE: begin
               next_s.bresp = msr_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (s.bvalid && axiReq.bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s.rvalid && axiReq.rready) begin
         next_s.rvalid = 1'b0;
      end
      if (axiReq.arvalid && arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = msr_pkg::RESP_OKAY;
         unique case (regKind(axiReq.araddr))
            msr_pkg::RK_CFG: next_s.rdata = s.cfg[axiReq.araddr[4:2]];
            msr_pkg::RK_STAT: next_s.rdata = {16'h0000, s.rejCnt, 5'h00, s.state};
            msr_pkg::RK_TAB: next_s.rdata = {23'h000000, tab[axiReq.araddr[9:2]]};
            msr_pkg::RK_NONE: begin
               next_s.rdata = 32'h00000000;
               next_s.rresp = msr_pkg::RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '{cfg: msr_pkg::CFG_RST, state: msr_pkg::ST_IDLE, tx: '{dest: msr_pkg::DST_PKT, addr: 8'h00},
            default: '0};
      end else begin
         s <= next_s;
      end
   end

   // Lookup table has no reset; software must fill it before enabling dual slave mode
   always_ff @(posedge mclk) begin
      if (tabWe) begin
         tab[tabIx] <= tabWd;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign msgReady = (s.state == msr_pkg::ST_IDLE);
   assign rts = s.viaRts && (s.state == msr_pkg::ST_RTS || s.state == msr_pkg::ST_SEND); // see (R20)
   assign txValid = (s.state == msr_pkg::ST_SEND);
   assign tx = s.tx;
   assign ansValid = s.ansValid;
   assign ans = s.ans;
   assign axiRsp = '{awready: awready, wready: wready, bvalid: s.bvalid, bresp: s.bresp, arready: arready,
      rvalid: s.rvalid, rdata: s.rdata, rresp: s.rresp};

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence seqMdmTake;
      msgValid && msgReady && mode == msr_pkg::MODE_MDM && !msg.fromPort;
   endsequence
   sequence seqDualTake;
      msgValid && msgReady && mode == msr_pkg::MODE_DUAL && msg.fromPort && !isMbFrame(msg) && msg.bccOk;
   endsequence

   chk_pkt_route: assert property (seqMdmTake ##0 (msg.drop1 <= 8'h63) |=> // see (R1)
      s.tx.dest == msr_pkg::DST_PKT && s.tx.addr == $past(msg.drop1) && s.state == msr_pkg::ST_RTS)
      else $error("Low drop not sent as packet");
   chk_mb_address: assert property (seqMdmTake ##0 (msg.drop1 inside {[8'h64:8'hC7]}) |=> // see (R2)
      s.tx.dest == msr_pkg::DST_MB && s.tx.addr == $past(msg.drop1) - 8'h64)
      else $error("Modbus address not drop minus 100");
   chk_no_repeater: assert property (seqMdmTake ##0 (msg.drop1 > 8'hC7) |=> // see (R4)
      ansValid && ans.err && s.state == msr_pkg::ST_IDLE)
      else $error("High drop not refused");
   chk_port_reject: assert property (msgValid && msgReady && mode == msr_pkg::MODE_MDM && msg.fromPort // see (R5)
      |=> s.state == msr_pkg::ST_IDLE && !ansValid)
      else $error("Port request accepted in master mode");
   chk_cts_wait: assert property (s.state == msr_pkg::ST_RTS && (!cts || s.timer < ctsWait) // see (R20)
      |=> s.state == msr_pkg::ST_RTS && rts)
      else $error("Sent without handshake");
   chk_mb_no_retry: assert property (s.state == msr_pkg::ST_WAIT && s.tx.dest == msr_pkg::DST_MB && timeUp // see (R7)
      && !replyIn |=> s.state != msr_pkg::ST_RTS ##0 ansValid && ans.err)
      else $error("Modbus query retried");
   chk_local_route: assert property (seqDualTake ##0 (msg.routeLen == 4'h0) |=> // see (R16)
      ansValid && ans.isLocal && !ans.err)
      else $error("Empty route not served locally");
   chk_single_answer: assert property (ansValid |=> !ansValid [*2]) // see (R14)
      else $error("Answer repeated");
   chk_mb_local: assert property (msgValid && msgReady && mode == msr_pkg::MODE_DUAL && msg.fromPort && // see (R17)
      isMbFrame(msg) && msg.mbAddr == 8'hFF |=> ansValid && ans.isLocal && s.state == msr_pkg::ST_IDLE)
      else $error("Address 255 not local");
endmodule // msr_router

// >>> verilog/msr_pkg.sv
// Constants, types and register map of the mixed protocol serial router.
// Assumes one clock (mclk, 25 MHz) and an AXI4-Lite master for software access.
// Operation
// (R1) Multidrop master: next drop 0..99 goes out as a radio net master packet.
// (R2) Multidrop master: next drop 100..199 becomes a Modbus query, address drop minus 100.
// (R3) Remote Modbus slaves never use address 16 on the multidrop network.
// (R4) No repeater routing; drops above the packet range never become repeater routes.
// (R5) Multidrop master only masters Modbus; incoming Modbus requests on the port are dropped.
// (R6) Handshake wait, pause time and message count govern both protocols.
// (R7) Unanswered Modbus queries are not retried; packets retry as usual.
// (R8) All radio net master devices share one network identifier.
// (R9) Manual and automatic token request polling work as on a plain master port.
// (R10) All slaves use the same serial framing as the master port.
// (R11) Modbus slaves stay silent for foreign queries and never forward them.
// (R12) Dual slave: the attached device is master; the port never starts traffic.
// (R13) Attached master keeps at most one request outstanding.
// (R14) Dual slave: each routed request gets exactly one data or error answer.
// (R15) Routed requests start with the port drop or the wildcard drop 201.
// (R16) A routed request with an empty route is served locally.
// (R17) Dual slave Modbus uses the lookup table; address 255 means local access.
// (R18) Addresses 16 and 254 are never entered in the lookup table.
// (R19) With meter poll subset slaves, network identifier and handshake wait are zero.
// (R20) Raise RTS, then send after the handshake wait and CTS; zero wait means CTS only.
// (R21) Dual slave classifies each frame as routed request or Modbus query.
package msr_pkg;
   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_DROP = 12'h004;
   localparam logic [11:0] ADDR_CTS = 12'h008;
   localparam logic [11:0] ADDR_PACE = 12'h00C;
   localparam logic [11:0] ADDR_RETRY = 12'h010;
   localparam logic [11:0] ADDR_TOUT = 12'h014;
   localparam logic [11:0] ADDR_TOKEN = 12'h018;
   localparam logic [11:0] ADDR_STAT = 12'h01C;
   localparam logic [11:0] ADDR_TAB = 12'h400;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_AUTO = 2;
   localparam int CTRL_POLL = 3;
   localparam int PACE_CNT_LSB = 16;
   localparam int TAB_VALID = 8;
   localparam logic [6:0][31:0] CFG_MASK = {32'h0000FFFF, 32'h0000FFFF, 32'h0000000F,
      32'h00FFFFFF, 32'h0000FFFF, 32'h000000FF, 32'h0000000F};
   localparam logic [6:0][31:0] CFG_RST = {32'h00000000, 32'h000000C8, 32'h00000001,
      32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000};
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ************************************************************
   // Drop numbers and timing
   // ************************************************************
   localparam logic [7:0] DROP_PKT_MAX = 8'h63;
   localparam logic [7:0] DROP_MB_LO = 8'h64;
   localparam logic [7:0] DROP_MB_HI = 8'hC7;
   localparam logic [7:0] DROP_WILD = 8'hC9;
   localparam logic [7:0] MB_LOCAL = 8'hFF;
   localparam int TICK_NS = 1000000;
   localparam int CLK_NS = 40;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {MODE_OFF = 2'b00, MODE_MDM = 2'b01, MODE_DUAL = 2'b10} msr_mode_t;
   typedef enum logic [1:0] {DST_PKT = 2'b00, DST_MB = 2'b01, DST_FWD = 2'b10, DST_POLL = 2'b11} msr_dest_t;
   typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_RTS = 3'b001, ST_SEND = 3'b010, ST_WAIT = 3'b011,
      ST_PAUSE = 3'b100} msr_state_t;
   typedef enum logic [1:0] {RK_CFG = 2'b00, RK_STAT = 2'b01, RK_TAB = 2'b10, RK_NONE = 2'b11} msr_rkind_t;
   typedef struct packed {
      logic awvalid;
      logic [11:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [11:0] araddr;
      logic rready;
   } msr_axi_req_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } msr_axi_rsp_t;
   typedef struct packed {
      logic fromPort;
      logic crcOk;
      logic bccOk;
      logic [3:0] routeLen;
      logic [7:0] drop0;
      logic [7:0] drop1;
      logic [7:0] mbAddr;
   } msr_msg_t;
   typedef struct packed {
      msr_dest_t dest;
      logic [7:0] addr;
   } msr_tx_t;
   typedef struct packed {
      logic err;
      logic isLocal;
   } msr_ans_t;
endpackage

// >>> dv/msr_far_model.sv
// Far side of the router: remote slaves on the multidrop line.
// Assumes rts and txValid are levels on mclk.
`timescale 1ns/100ps
module msr_far_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic rts,
   input wire logic txValid,
   input wire logic ctsSlow,
   input wire logic replyOn,
   output logic cts,
   output logic txDone,
   output logic replyIn
);
   logic [2:0] lag;
   logic [1:0] rDly;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lag <= 3'h0;
         cts <= 1'b0;
         txDone <= 1'b0;
         rDly <= 2'h0;
         replyIn <= 1'b0;
      end else begin
         lag <= rts ? lag + {2'h0, lag != 3'h7} : 3'h0;
         cts <= rts && (lag >= (ctsSlow ? 3'h3 : 3'h0));
         txDone <= txValid && !txDone;
         // Silent while replyOn is low, so a query then just times out
         rDly <= {rDly[0], txDone && replyOn};
         // All stations share one network identifier, so no filtering on it here
         replyIn <= rDly[1];
      end
   end
endmodule // msr_far_model

// >>> dv/mixed_protocol_serial_router_tb.sv
// Self-checking bench of the serial router.
// Assumes msr_router and msr_far_model compiled before it.
`timescale 1ns/100ps
module mixed_protocol_serial_router_tb;
   // ****
   // Harness
   // ****
   logic mclk = 0;
   logic rst_n = 0;
   msr_pkg::msr_axi_req_t req = '0;
   msr_pkg::msr_axi_rsp_t rsp;
   msr_pkg::msr_msg_t msg = '0, m2;
   msr_pkg::msr_tx_t tx;
   msr_pkg::msr_ans_t ans, a;
   logic msgValid = 0;
   logic msgReady, rts, cts, txValid, txDone, replyIn, ansValid;
   logic ctsSlow = 0;
   logic replyOn = 1;
   logic [31:0] rd;
   logic [1:0] resp;
   // Modbus drops keep clear of slave address 16
   logic [7:0] dl [4] = '{8'h00, 8'h63, 8'h64, 8'hC7};
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   int sends, got;
   always #20 mclk = ~mclk;
   msr_router #(.TICK_CYC(4)) i_dut (.mclk(mclk), .rst_n(rst_n), .axiReq(req), .axiRsp(rsp), .msgValid(msgValid),
      .msgReady(msgReady), .msg(msg), .rts(rts), .cts(cts), .txValid(txValid), .txDone(txDone), .tx(tx),
      .replyIn(replyIn), .ansValid(ansValid), .ans(ans));
   msr_far_model i_far (.mclk(mclk), .rst_n(rst_n), .rts(rts), .txValid(txValid), .ctsSlow(ctsSlow),
      .replyOn(replyOn), .cts(cts), .txDone(txDone), .replyIn(replyIn));
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task end_of_test;
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 12000) begin
         num_errors++;
         end_of_test();
      end
   end
   // ****
   // Access tasks; ready and valid are sampled mid-cycle, acted on at the edge
   // ****
   task axi_wr(input logic [11:0] ad, input logic [31:0] d);
      logic aw, w, bv;
      req.awvalid <= 1'b1;
      req.awaddr <= ad;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      forever begin
         @(negedge mclk);
         aw = rsp.awready;
         w = rsp.wready;
         bv = rsp.bvalid;
         resp = rsp.bresp;
         @(posedge mclk);
         if (aw) req.awvalid <= 1'b0;
         if (w) req.wvalid <= 1'b0;
         if (bv) break;
      end
      req.bready <= 1'b0;
      @(posedge mclk);
   endtask
   task axi_rd(input logic [11:0] ad);
      logic ar, rv;
      req.arvalid <= 1'b1;
      req.araddr <= ad;
      req.rready <= 1'b1;
      forever begin
         @(negedge mclk);
         ar = rsp.arready;
         rv = rsp.rvalid;
         rd = rsp.rdata;
         resp = rsp.rresp;
         @(posedge mclk);
         if (ar) req.arvalid <= 1'b0;
         if (rv) break;
      end
      req.rready <= 1'b0;
      @(posedge mclk);
   endtask
   function automatic msr_pkg::msr_msg_t mk(logic fp, logic crc, logic bcc, logic [3:0] len, logic [7:0] d1,
      logic [7:0] mb);
      mk = {fp, crc, bcc, len, 8'h35, d1, mb};
   endfunction
   // One request at a time; a fixed window catches late or doubled answers
   task send(input msr_pkg::msr_msg_t m);
      msg <= m;
      msgValid <= 1'b1;
      do @(negedge mclk); while (msgReady !== 1'b1);
      @(posedge mclk);
      msgValid <= 1'b0;
      sends = 0;
      got = 0;
      repeat (300) begin
         @(negedge mclk);
         sends += int'(txValid && txDone);
         if (ansValid === 1'b1) begin
            got++;
            a = ans;
         end
      end
      @(posedge mclk);
   endtask
   // ****
   // Tests
   // ****
   initial begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      axi_rd(msr_pkg::ADDR_RETRY);
      check("retry reset", rd, 32'h1);
      axi_rd(msr_pkg::ADDR_TOUT);
      check("timeout reset", rd, 32'hC8);
      axi_rd(12'h020);
      check("unmapped resp", {30'h0, resp}, {30'h0, msr_pkg::RESP_SLVERR});
      axi_wr(msr_pkg::ADDR_STAT, 32'h0);
      check("status write resp", {30'h0, resp}, {30'h0, msr_pkg::RESP_SLVERR});
      $display("test registers done");
      axi_wr(msr_pkg::ADDR_CTRL, 32'h1);
      axi_wr(msr_pkg::ADDR_DROP, 32'h35);
      axi_wr(msr_pkg::ADDR_CTS, 32'h1);
      ctsSlow <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         send(mk(1'b0, 1'b0, 1'b0, 4'h2, dl[i], 8'h00));
         check("dest", tx.dest, dl[i] < 8'h64 ? msr_pkg::DST_PKT : msr_pkg::DST_MB);
         check("addr", tx.addr, dl[i] < 8'h64 ? dl[i] : dl[i] - 8'h64);
         check("answer ok", {got[30:0], a.err}, {31'h1, 1'b0});
      end
      send(mk(1'b0, 1'b0, 1'b0, 4'h2, 8'hC8, 8'h00));
      check("drop 200", {sends[30:0], a.err}, {31'h0, 1'b1});
      send(mk(1'b1, 1'b1, 1'b0, 4'h0, 8'h00, 8'h05));
      check("slave query", got, 0);
      axi_rd(msr_pkg::ADDR_STAT);
      check("reject count", rd[15:8], 8'h01);
      replyOn <= 1'b0;
      axi_wr(msr_pkg::ADDR_RETRY, 32'h3);
      axi_wr(msr_pkg::ADDR_TOUT, 32'h2);
      axi_wr(msr_pkg::ADDR_CTS, 32'h0);
      send(mk(1'b0, 1'b0, 1'b0, 4'h2, 8'h69, 8'h00));
      check("modbus tries", sends, 1);
      send(mk(1'b0, 1'b0, 1'b0, 4'h2, 8'h05, 8'h00));
      check("packet tries", sends, 3);
      axi_wr(msr_pkg::ADDR_TOKEN, 32'h1);
      axi_wr(msr_pkg::ADDR_CTRL, 32'h5);
      repeat (60) @(posedge mclk);
      check("auto poll", {tx.dest, tx.addr}, {msr_pkg::DST_POLL, 8'h35});
      axi_wr(msr_pkg::ADDR_CTRL, 32'h9);
      repeat (60) @(posedge mclk);
      axi_rd(msr_pkg::ADDR_CTRL);
      check("manual poll start", rd, 32'h1);
      $display("test multidrop done");
      // Only the attached master starts exchanges in this mode
      axi_wr(msr_pkg::ADDR_CTRL, 32'h2);
      axi_wr(12'h404, 32'h107);
      send(mk(1'b1, 1'b0, 1'b1, 4'h0, 8'h00, 8'h00));
      check("empty route", {got[30:0], a.isLocal}, {31'h1, 1'b1});
      send(mk(1'b1, 1'b1, 1'b0, 4'h0, 8'h00, 8'hFF));
      check("modbus local", {got[30:0], a.isLocal}, {31'h1, 1'b1});
      send(mk(1'b1, 1'b0, 1'b0, 4'h0, 8'h00, 8'h01));
      check("bad frame", got, 0);
      replyOn <= 1'b1;
      send(mk(1'b1, 1'b1, 1'b0, 4'h0, 8'h00, 8'h01));
      check("table route", {tx.dest, tx.addr}, {msr_pkg::DST_FWD, 8'h07});
      send(mk(1'b1, 1'b0, 1'b1, 4'h2, 8'h0A, 8'h00));
      check("routed reply", {got[30:0], a.err}, {31'h1, 1'b0});
      replyOn <= 1'b0;
      send(mk(1'b1, 1'b0, 1'b1, 4'h2, 8'h0A, 8'h00));
      check("routed timeout", {got[30:0], a.err}, {31'h1, 1'b1});
      send(mk(1'b1, 1'b1, 1'b0, 4'h0, 8'h00, 8'h01));
      check("modbus fwd silent", {sends[15:0], got[15:0]}, {16'h1, 16'h0});
      m2 = mk(1'b1, 1'b0, 1'b1, 4'h2, 8'h0A, 8'h00);
      m2.drop0 = msr_pkg::DROP_WILD;
      send(m2);
      check("wildcard drop", {sends[15:0], got[14:0], a.err}, {16'h1, 15'h1, 1'b1});
      m2.drop0 = 8'h36;
      send(m2);
      check("foreign drop", {sends[15:0], got[14:0], a.err}, {16'h0, 15'h1, 1'b1});
      $display("test dual slave done");
      end_of_test();
   end
endmodule // mixed_protocol_serial_router_tb
